/* design/xbp_pkg.sv */
// Constants, types and timing for the external bus and port one pin logic.
// Assumes CORE_CLK stands in for the oscillator input and one shared reset.
package xbp_pkg;

   // =========================================================
   // Timing
   localparam int CORE_PERIOD_NS   = 8;
   localparam int OSC_PERIOD_NS    = 32;
   localparam int QUARTERS_PER_OSC = 4;
   localparam int BUS_PERIOD_OSC   = 4;
   localparam int QUARTER_DIV_CALC = OSC_PERIOD_NS / (QUARTERS_PER_OSC * CORE_PERIOD_NS);
   localparam int QUARTER_DIV_DFLT = (QUARTER_DIV_CALC < 1) ? 1 : QUARTER_DIV_CALC;
   localparam int SLOTS            = QUARTERS_PER_OSC * BUS_PERIOD_OSC;

   // Latch strobe 1.5 osc cycles, fetch strobe 2.25 osc cycles, in quarter slots
   localparam logic [3:0] ALE_HIGH_SLOTS  = 4'h6;
   localparam logic [3:0] PROGRAM_FETCH_STROBE_N_LOW_SLOTS  = 4'h9;
   localparam logic [3:0] LAST_SLOT       = 4'hF;
   localparam logic [3:0] PROGRAM_FETCH_STROBE_N_FALL_SLOT  = 4'(SLOTS - 9);
   localparam logic [3:0] WR_LAST_SLOT    = 4'hE;
   localparam logic [3:0] SLOT_STEP       = 4'h1;

   // Strong high driver on-time, in quarter slots (one osc cycle)
   localparam logic [2:0] STRONG_PULSE_SLOTS = 3'h4;

   // =========================================================
   // Reset values and pin positions
   localparam logic [7:0] PORT_RESET   = 8'hFF;
   localparam logic [7:0] ADDR_HI_RST  = 8'hFF;
   localparam int         BIT_T2_IO    = 0;
   localparam int         BIT_T2_TRIG  = 1;
   localparam int         BIT_SER_RX   = 2;
   localparam int         BIT_SER_TX   = 3;
   localparam int         BIT_IRQ_BASE = 4;
   localparam int         IRQ_COUNT    = 4;

   // =========================================================
   // Types
   typedef enum logic [1:0] {
      XBP_FETCH,
      XBP_DATA_RD,
      XBP_DATA_WR
   } xbp_kind_e;

   typedef struct packed {
      xbp_kind_e   kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } xbp_req_s;

endpackage : xbp_pkg

/* design/xbp_top.sv */
// External memory bus sequencer and quasi-bidirectional port one.
// Assumes the core requests accesses on CORE_CLK and pins are off-chip.
module xbp_top
   import xbp_pkg::*;
#(
   parameter int QUARTER_DIV = QUARTER_DIV_DFLT
)(
   // Clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 SYS_RST,
   // Core bus requests
   input  wire logic                 REQ_VALID,
   input  wire xbp_req_s             REQ,
   output logic                      REQ_READY,
   output logic                      RSP_VALID,
   output logic [7:0]                RSP_RDATA,
   // External bus pins
   output logic                      ADDR_LATCH_STROBE,
   output logic                      PROGRAM_FETCH_STROBE_N,
   input  wire logic [7:0]           MUXED_ADDR_DATA_BUS_IN,
   output logic [7:0]                MUXED_ADDR_DATA_BUS_OUT,
   output logic [7:0]                MUXED_ADDR_DATA_BUS_OE,
   output logic [7:0]                HIGH_ADDRESS_PORT,
   output logic                      DATA_READ_STROBE_N,
   output logic                      DATA_WRITE_STROBE_N,
   // Port one, core side
   input  wire logic                 GP_PORT_ONE_WR,
   input  wire logic [7:0]           GP_PORT_ONE_WDATA,
   input  wire logic                 TIMER_TWO_EXT_IO_OUT,
   input  wire logic                 SERIAL_ONE_TRANSMIT,
   output logic [7:0]                GP_PORT_ONE_LEVEL,
   output logic                      TIMER_TWO_EXT_IO_IN,
   output logic                      TIMER_TWO_CAPTURE_TRIGGER,
   output logic                      SERIAL_ONE_RECEIVE,
   // Port one pins
   input  wire logic [7:0]           GP_PORT_ONE_PINS_IN,
   output logic [7:0]                GP_PORT_ONE_PINS_OUT,
   output logic [7:0]                GP_PORT_ONE_PINS_OE,
   output logic [7:0]                GP_PORT_ONE_WEAK_PU,
   // External interrupts: two, three, four, five
   output logic [IRQ_COUNT-1:0]      EXT_IRQ_PENDING,
   input  wire logic [IRQ_COUNT-1:0] EXT_IRQ_CLEAR
);

   // Elaboration-time refusal: the divider counter is eight bits wide
   if (QUARTER_DIV < 1 || QUARTER_DIV > 255) begin : g_div_check
      $error("QUARTER_DIV out of range");
   end

   // =========================================================
   // Quarter-osc-cycle tick
   // CORE_CLK acts as the oscillator input; a crystal or an external
   // clock source feeding it is the board's business.
   logic [7:0] div_cnt;
   logic       tick;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else if (div_cnt == 8'(QUARTER_DIV - 1)) begin
         div_cnt <= 8'h00;
         tick    <= 1'b1;
      end else begin
         div_cnt <= 8'(div_cnt + 8'h01);
         tick    <= 1'b0;
      end
   end

   // =========================================================
   // Bus period slot counter
   logic [3:0] slot;
   logic [3:0] next_slot;
   logic       period_end;

   assign next_slot  = 4'(slot + SLOT_STEP);
   assign period_end = tick && (slot == LAST_SLOT);

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         slot <= LAST_SLOT;
      end else if (tick) begin
         slot <= next_slot;
      end
   end

   // =========================================================
   // Request holding and active access
   xbp_req_s pend;
   logic     pend_valid;
   xbp_req_s act;
   logic     act_valid;
   logic     take;

   assign take = REQ_VALID && REQ_READY;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pend       <= '0;
         pend_valid <= 1'b0;
      end else if (take) begin
         pend       <= REQ;
         pend_valid <= 1'b1;
      end else if (period_end) begin
         pend_valid <= 1'b0;
      end
   end

   // Ready only while the holding slot is empty, so requests never drop
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REQ_READY <= 1'b0;
      end else if (take) begin
         REQ_READY <= 1'b0;
      end else if (period_end || !pend_valid) begin
         REQ_READY <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         act       <= '0;
         act_valid <= 1'b0;
      end else if (period_end) begin
         act       <= pend;
         act_valid <= pend_valid;
      end
   end

   // Values of the access that runs in the slot being entered
   xbp_req_s cur;
   logic     cur_valid;

   always_comb begin
      cur       = act;
      cur_valid = act_valid;
      if (period_end) begin
         cur       = pend;
         cur_valid = pend_valid;
      end
   end

   // =========================================================
   // Strobes: latch strobe every period, fetch strobe on fetches
   logic next_ale;
   logic next_program_fetch_strobe_n_n;
   logic next_rd_n;
   logic next_wr_n;

   always_comb begin
      next_ale    = (next_slot < ALE_HIGH_SLOTS);
      next_program_fetch_strobe_n_n = 1'b1;
      next_rd_n   = 1'b1;
      next_wr_n   = 1'b1;
      if (cur_valid) begin
         case (cur.kind)
            XBP_FETCH: begin
               next_program_fetch_strobe_n_n = !(next_slot >= PROGRAM_FETCH_STROBE_N_FALL_SLOT);
            end
            XBP_DATA_RD: begin
               next_rd_n = !(next_slot >= PROGRAM_FETCH_STROBE_N_FALL_SLOT);
            end
            XBP_DATA_WR: begin
               next_wr_n = !((next_slot >= PROGRAM_FETCH_STROBE_N_FALL_SLOT) && (next_slot <= WR_LAST_SLOT));
            end
            default: begin
               next_program_fetch_strobe_n_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ADDR_LATCH_STROBE      <= 1'b1;
         PROGRAM_FETCH_STROBE_N <= 1'b1;
         DATA_READ_STROBE_N     <= 1'b1;
         DATA_WRITE_STROBE_N    <= 1'b1;
      end else if (tick) begin
         ADDR_LATCH_STROBE      <= next_ale;
         PROGRAM_FETCH_STROBE_N <= next_program_fetch_strobe_n_n;
         DATA_READ_STROBE_N     <= next_rd_n;
         DATA_WRITE_STROBE_N    <= next_wr_n;
      end
   end

   // =========================================================
   // Multiplexed address/data lines and high address port
   // Driven only by the sequencer; software has no latch here.
   logic [7:0] next_ad_out;
   logic [7:0] next_ad_oe;

   always_comb begin
      next_ad_out = PORT_RESET;
      next_ad_oe  = PORT_RESET;
      if (cur_valid) begin
         if (next_slot < ALE_HIGH_SLOTS) begin
            next_ad_out = cur.addr[7:0];
         end else if (cur.kind == XBP_DATA_WR) begin
            next_ad_out = cur.wdata;
         end else begin
            next_ad_oe  = '0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MUXED_ADDR_DATA_BUS_OUT <= PORT_RESET;
         MUXED_ADDR_DATA_BUS_OE  <= PORT_RESET;
      end else if (tick) begin
         MUXED_ADDR_DATA_BUS_OUT <= next_ad_out;
         MUXED_ADDR_DATA_BUS_OE  <= next_ad_oe;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         HIGH_ADDRESS_PORT <= ADDR_HI_RST;
      end else if (tick && cur_valid && (next_slot == '0)) begin
         HIGH_ADDRESS_PORT <= cur.addr[15:8];
      end
   end

   // =========================================================
   // Read data capture
   // Bus input passes two flops, so data must be stable two core
   // cycles before the end of the period.
   logic [7:0] ad_meta;
   logic [7:0] ad_sync;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ad_meta <= PORT_RESET;
         ad_sync <= PORT_RESET;
      end else begin
         ad_meta <= MUXED_ADDR_DATA_BUS_IN;
         ad_sync <= ad_meta;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RSP_VALID <= 1'b0;
         RSP_RDATA <= '0;
      end else begin
         RSP_VALID <= 1'b0;
         if (period_end && act_valid && (act.kind != XBP_DATA_WR)) begin
            RSP_VALID <= 1'b1;
            RSP_RDATA <= ad_sync;
         end
      end
   end

   // =========================================================
   // Port one quasi-bidirectional pins
   logic [7:0] p1_latch;
   logic [7:0] p1_eff;
   logic [7:0] p1_eff_prev;
   logic [7:0] p1_meta;
   logic [7:0] p1_sync;
   logic [7:0] p1_prev;

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         p1_latch <= PORT_RESET;
      end else if (GP_PORT_ONE_WR) begin
         p1_latch <= GP_PORT_ONE_WDATA;
      end
   end

   // Alternate outputs pull a bit low only while its latch holds one
   always_comb begin
      p1_eff              = p1_latch;
      p1_eff[BIT_T2_IO]   = p1_latch[BIT_T2_IO] & TIMER_TWO_EXT_IO_OUT;
      p1_eff[BIT_SER_TX]  = p1_latch[BIT_SER_TX] & SERIAL_ONE_TRANSMIT;
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         p1_eff_prev <= PORT_RESET;
      end else begin
         p1_eff_prev <= p1_eff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p1
         logic [2:0] boost;

         always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               boost <= '0;
            end else if (p1_eff[gi] && !p1_eff_prev[gi]) begin
               boost <= STRONG_PULSE_SLOTS;
            end else if (!p1_eff[gi]) begin
               boost <= '0;
            end else if (tick && (boost != '0)) begin
               boost <= 3'(boost - 3'h1);
            end
         end

         always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               GP_PORT_ONE_PINS_OUT[gi] <= 1'b1;
               GP_PORT_ONE_PINS_OE[gi]  <= 1'b0;
               GP_PORT_ONE_WEAK_PU[gi]  <= 1'b1;
            end else if (!p1_eff[gi]) begin
               GP_PORT_ONE_PINS_OUT[gi] <= 1'b0;
               GP_PORT_ONE_PINS_OE[gi]  <= 1'b1;
               GP_PORT_ONE_WEAK_PU[gi]  <= 1'b0;
            end else if ((p1_eff[gi] && !p1_eff_prev[gi]) || (boost > 3'h1) ||
                         ((boost == 3'h1) && !tick)) begin
               GP_PORT_ONE_PINS_OUT[gi] <= 1'b1;
               GP_PORT_ONE_PINS_OE[gi]  <= 1'b1;
               GP_PORT_ONE_WEAK_PU[gi]  <= 1'b1;
            end else begin
               GP_PORT_ONE_PINS_OUT[gi] <= 1'b1;
               GP_PORT_ONE_PINS_OE[gi]  <= 1'b0;
               GP_PORT_ONE_WEAK_PU[gi]  <= 1'b1;
            end
         end
      end
   endgenerate

   // Pin levels: two-flop synchroniser, then a third stage for edges
   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         p1_meta <= PORT_RESET;
         p1_sync <= PORT_RESET;
         p1_prev <= PORT_RESET;
      end else begin
         p1_meta <= GP_PORT_ONE_PINS_IN;
         p1_sync <= p1_meta;
         p1_prev <= p1_sync;
      end
   end

   always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         GP_PORT_ONE_LEVEL         <= PORT_RESET;
         TIMER_TWO_EXT_IO_IN       <= 1'b1;
         TIMER_TWO_CAPTURE_TRIGGER <= 1'b1;
         SERIAL_ONE_RECEIVE        <= 1'b1;
      end else begin
         GP_PORT_ONE_LEVEL         <= p1_sync;
         TIMER_TWO_EXT_IO_IN       <= p1_sync[BIT_T2_IO];
         TIMER_TWO_CAPTURE_TRIGGER <= p1_sync[BIT_T2_TRIG];
         SERIAL_ONE_RECEIVE        <= p1_sync[BIT_SER_RX];
      end
   end

   // =========================================================
   // Edge-detected external interrupts
   // Even index rises (two, four), odd index falls (three, five).
   generate
      for (gi = 0; gi < IRQ_COUNT; gi++) begin : g_irq
         logic edge_seen;

         if ((gi % 2) == 0) begin : g_rise
            assign edge_seen = p1_sync[BIT_IRQ_BASE+gi] && !p1_prev[BIT_IRQ_BASE+gi];
         end else begin : g_fall
            assign edge_seen = !p1_sync[BIT_IRQ_BASE+gi] && p1_prev[BIT_IRQ_BASE+gi];
         end

         // A new edge in the clearing cycle is kept
         always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
               EXT_IRQ_PENDING[gi] <= 1'b0;
            end else if (edge_seen) begin
               EXT_IRQ_PENDING[gi] <= 1'b1;
            end else if (EXT_IRQ_CLEAR[gi]) begin
               EXT_IRQ_PENDING[gi] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule : xbp_top

/* verif/xbp_properties.sv */
// Concurrent checks on the bus strobes, port one and interrupt flags of xbp_top.
// Assumes QUARTER_DIV of 1: one quarter slot is one CORE_CLK cycle.
module xbp_properties (
   // Clock and reset
   input wire logic       CORE_CLK,
   input wire logic       SYS_RST,
   // Bus side
   input wire logic       ADDR_LATCH_STROBE,
   input wire logic       PROGRAM_FETCH_STROBE_N,
   input wire logic       DATA_READ_STROBE_N,
   input wire logic       DATA_WRITE_STROBE_N,
   input wire logic       RSP_VALID,
   input wire logic [7:0] MUXED_ADDR_DATA_BUS_OUT,
   input wire logic [7:0] MUXED_ADDR_DATA_BUS_OE,
   // Port one and interrupts
   input wire logic       GP_PORT_ONE_WR,
   input wire logic [7:0] GP_PORT_ONE_WDATA,
   input wire logic [7:0] GP_PORT_ONE_PINS_IN,
   input wire logic [7:0] GP_PORT_ONE_PINS_OUT,
   input wire logic [7:0] GP_PORT_ONE_PINS_OE,
   input wire logic [7:0] GP_PORT_ONE_WEAK_PU,
   input wire logic [3:0] EXT_IRQ_PENDING,
   input wire logic [3:0] EXT_IRQ_CLEAR
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // =====================================================
   // Strobe shapes, 16 slots per bus period
   sequence s_latch_high;
      ADDR_LATCH_STROBE [*6] ##1 !ADDR_LATCH_STROBE;
   endsequence
   sequence s_latch_low;
      !ADDR_LATCH_STROBE [*8] ##1 !ADDR_LATCH_STROBE [*2] ##1 ADDR_LATCH_STROBE;
   endsequence
   sequence s_fetch_low;
      !PROGRAM_FETCH_STROBE_N [*8] ##1 !PROGRAM_FETCH_STROBE_N ##1 PROGRAM_FETCH_STROBE_N;
   endsequence
   a_latch_high_width: assert property ($rose(ADDR_LATCH_STROBE) |-> s_latch_high)
      else $error("latch strobe high width wrong");
   a_latch_period: assert property ($fell(ADDR_LATCH_STROBE) |-> s_latch_low)
      else $error("latch strobe period wrong");
   a_fetch_low_width: assert property ($fell(PROGRAM_FETCH_STROBE_N) |-> s_fetch_low)
      else $error("fetch strobe low width wrong");
   a_fetch_idle_data: assert property (!DATA_READ_STROBE_N || !DATA_WRITE_STROBE_N |-> PROGRAM_FETCH_STROBE_N)
      else $error("fetch strobe low in data access");
   // Only live while reset is applied, so it carries the opposite disable
   a_reset_forces: assert property (disable iff (!SYS_RST) ADDR_LATCH_STROBE && PROGRAM_FETCH_STROBE_N
      && (MUXED_ADDR_DATA_BUS_OE & MUXED_ADDR_DATA_BUS_OUT) == 8'hFF && GP_PORT_ONE_WEAK_PU == 8'hFF)
      else $error("reset levels wrong");
   a_addr_phase_drive: assert property (ADDR_LATCH_STROBE |-> MUXED_ADDR_DATA_BUS_OE == 8'hFF)
      else $error("address not driven under strobe");
   a_data_phase_free: assert property (!PROGRAM_FETCH_STROBE_N || !DATA_READ_STROBE_N |->
      MUXED_ADDR_DATA_BUS_OE == 8'h00 && !ADDR_LATCH_STROBE)
      else $error("bus not released for read");
   a_read_answer: assert property ($rose(PROGRAM_FETCH_STROBE_N) || $rose(DATA_READ_STROBE_N) |-> ##[0:2] RSP_VALID)
      else $error("read response missing");
   a_pull_down_on: assert property (GP_PORT_ONE_WR && GP_PORT_ONE_WDATA == 8'h00 |-> ##[1:3]
      (GP_PORT_ONE_PINS_OE == 8'hFF && GP_PORT_ONE_PINS_OUT == 8'h00))
      else $error("pull-down not enabled");
   a_strong_high_brief: assert property (GP_PORT_ONE_PINS_OE[0] && GP_PORT_ONE_PINS_OUT[0] |-> ##[1:6]
      (!GP_PORT_ONE_PINS_OE[0] && GP_PORT_ONE_WEAK_PU[0]))
      else $error("strong high driver stays on");
   a_irq_rise_flag: assert property ($rose(GP_PORT_ONE_PINS_IN[4]) && !EXT_IRQ_CLEAR[0] |-> ##[2:6] EXT_IRQ_PENDING[0])
      else $error("rising edge flag not set");
   a_irq_fall_flag: assert property ($fell(GP_PORT_ONE_PINS_IN[5]) && !EXT_IRQ_CLEAR[1] |-> ##[2:6] EXT_IRQ_PENDING[1])
      else $error("falling edge flag not set");
endmodule // xbp_properties

/* verif/xbp_mem_model.sv */
// Behavioural external memory: address latch, data store and a computed program pattern.
// The latch samples on the core clock while the strobe is high, so a strobe fall and
// an address change in one time step cannot race it into catching data.
// Assumes the bus pins of xbp_top; a released line shows a toggling pattern.
module xbp_mem_model (
   // Clock and strobes
   input wire logic        clk,
   input wire logic        ale,
   input wire logic        program_fetch_strobe_n_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        slow,
   // Address and data lines
   input wire logic [7:0]  hi,
   input wire logic [7:0]  ad_out,
   input wire logic [7:0]  ad_oe,
   output logic     [7:0]  ad_in,
   output logic     [15:0] last_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] lo, prev, rdat;
   logic [7:0] ram [256];
   logic [3:0] age;
   logic       drive;
   always_ff @(posedge clk) if (ale) lo <= ad_out;
   always_ff @(negedge ale) last_addr <= {hi, lo};
   always_ff @(posedge clk) age <= (program_fetch_strobe_n_n && rd_n) ? 4'h0 : age + 4'(age != 4'hF);
   always_ff @(posedge clk) prev <= ad_in;
   always_ff @(posedge clk) if (!wr_n) ram[lo] <= ad_in;
   // Slow answers still leave several cycles of settled data before the strobe ends
   assign drive = (!program_fetch_strobe_n_n || !rd_n) && (!slow || age >= 4'h4);
   assign rdat  = program_fetch_strobe_n_n ? ram[lo] : (hi ^ lo ^ 8'h5A);
   assign ad_in = (ad_oe & ad_out) | (~ad_oe & (drive ? rdat : ~prev));
endmodule // xbp_mem_model

/* verif/tb.sv */
// Self-checking bench for xbp_top: bus accesses, port one, interrupts, resets.
// Assumes the default QUARTER_DIV and the memory model on the bus pins.
module tb import xbp_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic        CORE_CLK, REQ_READY, RSP_VALID, ADDR_LATCH_STROBE, PROGRAM_FETCH_STROBE_N;
   logic        DATA_READ_STROBE_N, DATA_WRITE_STROBE_N;
   logic        TIMER_TWO_EXT_IO_IN, TIMER_TWO_CAPTURE_TRIGGER, SERIAL_ONE_RECEIVE;
   logic        SYS_RST;
   logic        REQ_VALID = 1'b0, GP_PORT_ONE_WR = 1'b0, slow = 1'b0;
   logic        TIMER_TWO_EXT_IO_OUT = 1'b1, SERIAL_ONE_TRANSMIT = 1'b1;
   xbp_req_s    REQ = '0;
   logic [7:0]  RSP_RDATA, MUXED_ADDR_DATA_BUS_IN, MUXED_ADDR_DATA_BUS_OUT, MUXED_ADDR_DATA_BUS_OE;
   logic [7:0]  HIGH_ADDRESS_PORT, GP_PORT_ONE_LEVEL, GP_PORT_ONE_PINS_IN;
   logic [7:0]  GP_PORT_ONE_PINS_OUT, GP_PORT_ONE_PINS_OE, GP_PORT_ONE_WEAK_PU;
   logic [7:0]  GP_PORT_ONE_WDATA = 8'h00, p1_en = 8'h00, p1_val = 8'h00;
   logic [3:0]  EXT_IRQ_PENDING, EXT_IRQ_CLEAR = 4'h0;
   logic [15:0] mem_addr;
   int          n_fail = 0, checks_done = 0;
   // Weak pull-up stands unless the module or the bench drives the pin
   assign GP_PORT_ONE_PINS_IN = (GP_PORT_ONE_PINS_OE & GP_PORT_ONE_PINS_OUT)
      | (~GP_PORT_ONE_PINS_OE & ((p1_en & p1_val) | (~p1_en & GP_PORT_ONE_WEAK_PU)));
   initial begin
      CORE_CLK = 1'b0;
      forever #4 CORE_CLK = ~CORE_CLK;
   end
   // =====================================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic give_up;
      n_fail++;
      end_sim();
   endtask
   // Scheduled late so the asynchronous reset sees a real edge even at time zero
   task automatic t_reset;
      SYS_RST <= 1'b1;
      repeat (8) @(negedge CORE_CLK);
      check("latch strobe", ADDR_LATCH_STROBE, 1'b1);
      check("fetch strobe", PROGRAM_FETCH_STROBE_N, 1'b1);
      check("muxed oe out", {MUXED_ADDR_DATA_BUS_OE, MUXED_ADDR_DATA_BUS_OUT}, 16'hFFFF);
      check("port oe pullup", {GP_PORT_ONE_PINS_OE, GP_PORT_ONE_WEAK_PU}, 16'h00FF);
      check("port pins", GP_PORT_ONE_PINS_IN, 8'hFF);
      check("high address", HIGH_ADDRESS_PORT, 8'hFF);
      check("pending", EXT_IRQ_PENDING, 4'h0);
      SYS_RST = 1'b0;
   endtask
   // A clock edge passes first, so back-to-back calls never retoggle the valid
   task automatic send(input xbp_kind_e k, input logic [15:0] a, input logic [7:0] d);
      int n;
      @(negedge CORE_CLK);
      REQ_VALID = 1'b1;
      REQ = '{k, a, d};
      for (n = 0; n < 80 && REQ_READY !== 1'b1; n++) @(negedge CORE_CLK);
      if (n == 80) give_up();
      @(negedge CORE_CLK);
      REQ_VALID = 1'b0;
   endtask
   task automatic rd_chk(input xbp_kind_e k, input logic [15:0] a, input logic [7:0] exp);
      int n;
      send(k, a, 8'h00);
      for (n = 0; n < 80 && RSP_VALID !== 1'b1; n++) @(negedge CORE_CLK);
      if (n == 80) give_up();
      check("read data", RSP_RDATA, exp);
      check("latched address", mem_addr, a);
   endtask
   task automatic wr_p1(input logic [7:0] d);
      GP_PORT_ONE_WR = 1'b1;
      GP_PORT_ONE_WDATA = d;
      @(negedge CORE_CLK);
      GP_PORT_ONE_WR = 1'b0;
   endtask
   task automatic clr(input logic [3:0] m);
      EXT_IRQ_CLEAR = m;
      @(negedge CORE_CLK);
      EXT_IRQ_CLEAR = 4'h0;
   endtask
   // =====================================================
   // Scenarios
   task automatic t_bus;
      rd_chk(XBP_FETCH, 16'h12A5, 8'h12 ^ 8'hA5 ^ 8'h5A);
      send(XBP_DATA_WR, 16'h8033, 8'h3C);
      rd_chk(XBP_DATA_RD, 16'h8033, 8'h3C);
      slow = 1'b1;
      send(XBP_DATA_WR, 16'h7FC3, 8'hA5);
      send(XBP_DATA_WR, 16'h0100, 8'h5A);
      rd_chk(XBP_DATA_RD, 16'h7FC3, 8'hA5);
      rd_chk(XBP_FETCH, 16'hFF00, 8'hFF ^ 8'h5A);
      send(XBP_FETCH, 16'h4444, 8'h00);
      repeat (20) @(negedge CORE_CLK);
      t_reset();
      slow = 1'b0;
      rd_chk(XBP_DATA_RD, 16'h0100, 8'h5A);
   endtask
   task automatic t_port;
      wr_p1(8'h00);
      repeat (3) @(negedge CORE_CLK);
      check("pull down", {GP_PORT_ONE_PINS_OE, GP_PORT_ONE_PINS_OUT}, 16'hFF00);
      repeat (30) @(negedge CORE_CLK);
      check("held low", GP_PORT_ONE_LEVEL, 8'h00);
      wr_p1(8'hFF);
      repeat (12) @(negedge CORE_CLK);
      check("weak high", {GP_PORT_ONE_PINS_OE, GP_PORT_ONE_WEAK_PU}, 16'h00FF);
      p1_en = 8'h07;
      p1_val = 8'h02;
      repeat (6) @(negedge CORE_CLK);
      check("alt inputs", {GP_PORT_ONE_LEVEL[2:0], TIMER_TWO_EXT_IO_IN, TIMER_TWO_CAPTURE_TRIGGER,
         SERIAL_ONE_RECEIVE}, 6'h12);
      p1_en = 8'h00;
      TIMER_TWO_EXT_IO_OUT = 1'b0;
      SERIAL_ONE_TRANSMIT = 1'b0;
      repeat (6) @(negedge CORE_CLK);
      check("alt outputs", {GP_PORT_ONE_PINS_IN[3], GP_PORT_ONE_PINS_IN[0]}, 2'h0);
      TIMER_TWO_EXT_IO_OUT = 1'b1;
      SERIAL_ONE_TRANSMIT = 1'b1;
      repeat (12) @(negedge CORE_CLK);
   endtask
   // Index i watches pin 4+i; odd indexes are falling-edge sources
   task automatic t_irq;
      int i;
      clr(4'hF);
      for (i = 0; i < 4; i++) begin
         p1_val[4+i] = 1'b0;
         p1_en[4+i] = 1'b1;
         repeat (8) @(negedge CORE_CLK);
         check("irq after fall", EXT_IRQ_PENDING, 4'(i % 2) << i);
         clr(4'h1 << i);
         p1_val[4+i] = 1'b1;
         repeat (8) @(negedge CORE_CLK);
         check("irq after rise", EXT_IRQ_PENDING, 4'(1 - i % 2) << i);
         clr(4'h1 << i);
         p1_en[4+i] = 1'b0;
         @(negedge CORE_CLK);
         check("irq cleared", EXT_IRQ_PENDING, 4'h0);
      end
   endtask
   initial begin
      t_reset();
      t_bus();
      t_port();
      t_irq();
      end_sim();
   end
   xbp_top u_xbp_top (.*);
   xbp_mem_model u_xbp_mem_model (.clk(CORE_CLK), .ale(ADDR_LATCH_STROBE), .program_fetch_strobe_n_n(PROGRAM_FETCH_STROBE_N),
      .rd_n(DATA_READ_STROBE_N), .wr_n(DATA_WRITE_STROBE_N), .slow(slow), .hi(HIGH_ADDRESS_PORT),
      .ad_out(MUXED_ADDR_DATA_BUS_OUT), .ad_oe(MUXED_ADDR_DATA_BUS_OE), .ad_in(MUXED_ADDR_DATA_BUS_IN),
      .last_addr(mem_addr));
endmodule // tb
bind xbp_top xbp_properties u_xbp_properties (.*);
